// ==== src/ppv_prom_programmer.sv ====
// byte-wide prom programmer: write pulses, verify reads and retry flow
// Overview of operation
// - program one byte per request, never pages
// - repeat short pulses, each followed by verify
// - pulse only addresses within the user area
// - above user area only erased bytes allowed
// - pulse widths 0.19-0.21 ms, overwrite to 5.25 ms (PULSE_CYC is only checked to lie within 1..OPW_MAX_CYC)
`default_nettype none
module ppv_prom_programmer #(
    parameter int PULSE_CYC = ppv_pkg::PW_CYC,
    parameter int OW_PULSE_CYC = ppv_pkg::OPW_CYC,
    parameter int RETRY_MAX = ppv_pkg::RETRY_MAX_DEF
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // user request
    input wire logic i_start,
    input wire logic i_verify_only,
    input wire logic [ppv_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ppv_pkg::DATA_W-1:0] i_data,
    // user answer
    output logic o_busy,
    output logic o_done,
    output logic o_fail,
    output logic o_range_err,
    output logic [ppv_pkg::DATA_W-1:0] o_read_data,
    // prom pins
    output logic o_chip_sel_n,
    output logic o_out_en_n,
    output logic o_program_strobe_n,
    output logic [ppv_pkg::ADDR_W-1:0] o_prom_address_bus,
    output logic [ppv_pkg::DATA_W-1:0] o_prom_data_bus,
    output logic o_prom_data_oe,
    input wire logic [ppv_pkg::DATA_W-1:0] i_prom_data_bus
);
    localparam int TW = ppv_pkg::TIMER_W;

    // parameter checks
    if (PULSE_CYC < 1 || PULSE_CYC > ppv_pkg::OPW_MAX_CYC) begin : g_bad_pulse
        $error("pulse count out of range");
    end
    if (OW_PULSE_CYC < PULSE_CYC || OW_PULSE_CYC > ppv_pkg::OPW_MAX_CYC) begin : g_bad_ow
        $error("overwrite pulse count out of range");
    end
    if (RETRY_MAX < 1 || RETRY_MAX > 254) begin : g_bad_retry
        $error("retry count out of range");
    end

    ppv_pkg::ppv_state_t state, next_state;
    logic [ppv_pkg::DATA_W-1:0] rd_sync1, rd_sync2;
    logic op_verify, next_op_verify, overwrite, next_overwrite;
    logic [ppv_pkg::ATTEMPT_W-1:0] attempts, next_attempts;
    logic [ppv_pkg::ADDR_W-1:0] next_prom_address_bus;
    logic [ppv_pkg::DATA_W-1:0] next_prom_data_bus, next_read_data;
    logic next_busy, next_done, next_fail, next_range_err;
    logic next_chip_sel_n, next_out_en_n, next_program_strobe_n, next_prom_data_oe;
    logic tmr_zero, tmr_load;
    logic [TW-1:0] tmr_value;
    // all assertions below run on the system clock, off during reset
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    // read data comes from the part, two flops before use
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_sync1 <= '0;
            rd_sync2 <= '0;
        end else begin
            rd_sync1 <= i_prom_data_bus;
            rd_sync2 <= rd_sync1;
        end
    end

    // sequencer next values
    always_comb begin
        next_state = state;
        next_op_verify = op_verify;
        next_overwrite = overwrite;
        next_attempts = attempts;
        next_prom_address_bus = o_prom_address_bus;
        next_prom_data_bus = o_prom_data_bus;
        next_read_data = o_read_data;
        next_fail = o_fail;
        next_range_err = o_range_err;
        next_done = 1'b0;
        case (state)
            ppv_pkg::ST_IDLE: begin
                if (i_start) begin
                    next_prom_address_bus = i_addr;
                    next_prom_data_bus = i_data;
                    next_op_verify = i_verify_only;
                    next_overwrite = 1'b0;
                    next_attempts = '0;
                    next_fail = 1'b0;
                    next_range_err = 1'b0;
                    if (i_verify_only) begin
                        next_state = ppv_pkg::ST_FLOAT;
                    end else if (i_addr > ppv_pkg::USER_TOP_ADDR) begin
                        // erased image above the top needs no pulse
                        next_range_err = (i_data != ppv_pkg::ERASED_BYTE);
                        next_fail = (i_data != ppv_pkg::ERASED_BYTE);
                        next_state = ppv_pkg::ST_FINISH;
                    end else begin
                        next_state = ppv_pkg::ST_SETUP;
                    end
                end
            end
            ppv_pkg::ST_SETUP: begin
                if (tmr_zero) begin
                    next_attempts = attempts + 1'b1;
                    next_state = ppv_pkg::ST_PULSE;
                end
            end
            ppv_pkg::ST_PULSE: begin
                if (tmr_zero) begin
                    next_state = ppv_pkg::ST_HOLD;
                end
            end
            ppv_pkg::ST_HOLD: begin
                if (tmr_zero) begin
                    next_state = ppv_pkg::ST_FLOAT;
                end
            end
            ppv_pkg::ST_FLOAT: begin
                if (tmr_zero) begin
                    next_state = ppv_pkg::ST_VERIFY;
                end
            end
            ppv_pkg::ST_VERIFY: begin
                if (tmr_zero) begin
                    next_read_data = rd_sync2;
                    next_state = ppv_pkg::ST_COMPARE;
                end
            end
            ppv_pkg::ST_COMPARE: begin
                // verify after every pulse decides the next step
                if (o_read_data == o_prom_data_bus || op_verify) begin
                    next_fail = (o_read_data != o_prom_data_bus);
                    next_state = ppv_pkg::ST_FINISH;
                end else if (overwrite) begin
                    next_fail = 1'b1;
                    next_state = ppv_pkg::ST_FINISH;
                end else if (attempts == ppv_pkg::ATTEMPT_W'(RETRY_MAX)) begin
                    next_overwrite = 1'b1;
                    next_state = ppv_pkg::ST_SETUP;
                end else begin
                    next_state = ppv_pkg::ST_SETUP;
                end
            end
            ppv_pkg::ST_FINISH: begin
                next_done = 1'b1;
                next_state = ppv_pkg::ST_IDLE;
            end
            default: begin
                next_state = ppv_pkg::ST_IDLE;
            end
        endcase
    end

    // pin levels follow the next state, only the five legal combinations
    always_comb begin
        next_busy = (next_state != ppv_pkg::ST_IDLE);
        next_chip_sel_n = (next_state == ppv_pkg::ST_IDLE) ||
                          (next_state == ppv_pkg::ST_FINISH);
        next_out_en_n = (next_state != ppv_pkg::ST_VERIFY);
        next_program_strobe_n = (next_state != ppv_pkg::ST_PULSE);
        next_prom_data_oe = (next_state == ppv_pkg::ST_SETUP) ||
                            (next_state == ppv_pkg::ST_PULSE) ||
                            (next_state == ppv_pkg::ST_HOLD);
    end

    // phase length loaded on every state change
    always_comb begin
        tmr_load = (next_state != state);
        case (next_state)
            ppv_pkg::ST_SETUP: tmr_value = TW'(ppv_pkg::SETUP_CYC - 1);
            ppv_pkg::ST_PULSE: tmr_value = next_overwrite ? TW'(OW_PULSE_CYC - 1)
                                                          : TW'(PULSE_CYC - 1);
            ppv_pkg::ST_HOLD: tmr_value = TW'(ppv_pkg::HOLD_CYC - 1);
            ppv_pkg::ST_FLOAT: tmr_value = TW'(ppv_pkg::DF_CYC - 1);
            ppv_pkg::ST_VERIFY: tmr_value = TW'(ppv_pkg::VERIFY_CYC - 1);
            default: tmr_value = '0;
        endcase
    end

    ppv_timer #(
        .WIDTH(TW)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_load(tmr_load),
        .i_value(tmr_value),
        .o_zero(tmr_zero)
    );

    // sequencer and pin registers
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ppv_pkg::ST_IDLE;
            op_verify <= 1'b0;
            overwrite <= 1'b0;
            attempts <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
            o_range_err <= 1'b0;
            o_read_data <= '0;
            o_chip_sel_n <= 1'b1;
            o_out_en_n <= 1'b1;
            o_program_strobe_n <= 1'b1;
            o_prom_address_bus <= '0;
            o_prom_data_bus <= '0;
            o_prom_data_oe <= 1'b0;
        end else begin
            state <= next_state;
            op_verify <= next_op_verify;
            overwrite <= next_overwrite;
            attempts <= next_attempts;
            o_busy <= next_busy;
            o_done <= next_done;
            o_fail <= next_fail;
            o_range_err <= next_range_err;
            o_read_data <= next_read_data;
            o_chip_sel_n <= next_chip_sel_n;
            o_out_en_n <= next_out_en_n;
            o_program_strobe_n <= next_program_strobe_n;
            o_prom_address_bus <= next_prom_address_bus;
            o_prom_data_bus <= next_prom_data_bus;
            o_prom_data_oe <= next_prom_data_oe;
        end
    end

    // helper: length of the current strobe low pulse
    logic [TW-1:0] low_cnt;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= !o_program_strobe_n ? low_cnt + 1'b1 : '0;
        end
    end

    property p_write_levels;
        !o_program_strobe_n |-> !o_chip_sel_n && o_out_en_n && o_prom_data_oe;
    endproperty
    a_write_levels: assert property (p_write_levels)
        else $error("strobe low outside write levels");
    property p_no_clash;
        !o_out_en_n |-> !o_prom_data_oe && o_program_strobe_n && !o_chip_sel_n;
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("data driven while part drives out");
    property p_one_byte;
        !o_chip_sel_n |=> $stable(o_prom_address_bus) || $past(o_chip_sel_n);
    endproperty
    a_one_byte: assert property (p_one_byte)
        else $error("address moved inside one byte transfer");
    property p_verify_follows;
        $rose(o_program_strobe_n) |-> ##[400:500] $fell(o_out_en_n);
    endproperty
    a_verify_follows: assert property (p_verify_follows)
        else $error("no verify read after program pulse");
    property p_in_range;
        $fell(o_program_strobe_n) |-> o_prom_address_bus <= ppv_pkg::USER_TOP_ADDR;
    endproperty
    a_in_range: assert property (p_in_range)
        else $error("pulse above user area");
    property p_erased_only;
        (state == ppv_pkg::ST_IDLE) && i_start && !i_verify_only &&
        (i_addr > ppv_pkg::USER_TOP_ADDR) && (i_data != ppv_pkg::ERASED_BYTE)
        |-> ##2 o_done && o_range_err && o_fail;
    endproperty
    a_erased_only: assert property (p_erased_only)
        else $error("non erased byte above top not refused");
    property p_pulse_width;
        $rose(o_program_strobe_n) |-> (low_cnt == TW'(PULSE_CYC)) ||
                                      (low_cnt == TW'(OW_PULSE_CYC));
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("program pulse width wrong");
    property p_fail_after_overwrite;
        o_done && o_fail && !o_range_err && !op_verify
        |-> overwrite && attempts == ppv_pkg::ATTEMPT_W'(RETRY_MAX + 1);
    endproperty
    a_fail_after_overwrite: assert property (p_fail_after_overwrite)
        else $error("failure reported before retries and overwrite");

    c_write_pass: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_done && !o_fail && !op_verify && attempts == 8'h01);
    c_overwrite: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        $fell(o_program_strobe_n) && overwrite);
    c_verify_only: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_done && op_verify);
    c_range_skip: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        o_done && o_range_err);
endmodule // ppv_prom_programmer
`default_nettype wire

// ==== src/ppv_pkg.sv ====
// constants and types shared by the prom program/verify controller
`default_nettype none
package ppv_pkg;
    // pin and counter widths
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int TIMER_W = 21;
    localparam int ATTEMPT_W = 8;
    // address map of the programmed part
    localparam logic [ADDR_W-1:0] USER_TOP_ADDR = 17'h0edff;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    // clock
    localparam int CLK_PERIOD_NS = 5;
    // pin timing in ns
    localparam int T_SETUP_NS = 2000;
    localparam int T_HOLD_NS = 2000;
    localparam int T_DF_NS = 130;
    localparam int T_OE_NS = 200;
    localparam int T_PW_NS = 200000;
    localparam int T_PW_MIN_NS = 190000;
    localparam int T_PW_MAX_NS = 210000;
    localparam int T_OPW_NS = 600000;
    localparam int T_OPW_MAX_NS = 5250000;
    // least times round up, longest times round down
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DF_CYC = (T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 2;
    localparam int VERIFY_CYC = OE_CYC + SYNC_CYC + 1;
    localparam int PW_CYC = T_PW_NS / CLK_PERIOD_NS;
    localparam int PW_MIN_CYC = (T_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PW_MAX_CYC = T_PW_MAX_NS / CLK_PERIOD_NS;
    localparam int OPW_CYC = T_OPW_NS / CLK_PERIOD_NS;
    localparam int OPW_MAX_CYC = T_OPW_MAX_NS / CLK_PERIOD_NS;
    // bounded retry count before the overwrite pulse
    localparam int RETRY_MAX_DEF = 25;
    // sequencer states, gray along the write path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_PULSE = 3'h3,
        ST_HOLD = 3'h2,
        ST_FLOAT = 3'h6,
        ST_VERIFY = 3'h7,
        ST_COMPARE = 3'h5,
        ST_FINISH = 3'h4
    } ppv_state_t;
endpackage
`default_nettype wire

// ==== src/ppv_timer.sv ====
// down counter that times each phase of the pin sequence
`default_nettype none
module ppv_timer #(
    parameter int WIDTH = 21
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // load request and value
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_value,
    // count reached zero
    output logic o_zero
);
    // width check
    if (WIDTH < 1) begin : g_bad_width
        $error("timer width out of range");
    end

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // load wins, otherwise count down and rest at zero
    always_comb begin
        if (i_load) begin
            next_count = i_value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end else begin
            next_count = count;
        end
    end

    // count register
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_zero = (count == '0);
endmodule // ppv_timer
`default_nettype wire

// ==== testbench/ppv_prom_model.sv ====
// behavioural prom device answering byte write and verify pin levels
`default_nettype none
module ppv_prom_model #(
    parameter int PW_NS = 100,
    parameter int OPW_NS = 300
) (
    // control pins
    input wire logic i_chip_sel_n,
    input wire logic i_out_en_n,
    input wire logic i_program_strobe_n,
    // address and data
    input wire logic [ppv_pkg::ADDR_W-1:0] i_prom_address_bus,
    input wire logic [ppv_pkg::DATA_W-1:0] i_prom_data_bus,
    output logic [ppv_pkg::DATA_W-1:0] o_prom_data_bus,
    output logic o_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    int need = 1; // pulses a byte needs before it takes, 0 never takes
    int hits = 0;
    int ow_hits = 0;
    int bad = 0;
    int high_hits = 0;
    realtime t_fall = 0.0;
    logic [7:0] last = 8'h00;

    // unwritten cells read erased
    function automatic logic [7:0] peek(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction

    // set slowness of the cells and clear hits and ow_hits, bad and high_hits keep counting
    task automatic clear(input int n);
        need = n;
        hits = 0;
        ow_hits = 0;
    endtask

    // only the verify levels drive the data pins
    assign o_drive = !i_chip_sel_n && !i_out_en_n && i_program_strobe_n;

    // released wire shows the inverse of the last driven byte
    always @* begin
        if (o_drive) begin
            o_prom_data_bus = peek(int'(i_prom_address_bus));
            last = o_prom_data_bus;
        end else begin
            o_prom_data_bus = ~last;
        end
    end

    // start of a program pulse
    always @(negedge i_program_strobe_n) t_fall = $realtime;

    // one byte taken per write pulse, width and address policed
    always @(posedge i_program_strobe_n) begin
        if (!i_chip_sel_n && i_out_en_n) begin
            hits++;
            if ($realtime - t_fall == OPW_NS) ow_hits++;
            else if ($realtime - t_fall != PW_NS) bad++;
            if (i_prom_address_bus > ppv_pkg::USER_TOP_ADDR) high_hits++;
            if (need != 0 && hits >= need) begin
                mem[int'(i_prom_address_bus)] =
                    peek(int'(i_prom_address_bus)) & i_prom_data_bus;
            end
        end
    end
endmodule // ppv_prom_model
`default_nettype wire

// ==== testbench/ppv_prom_programmer_test.sv ====
// self-checking bench for the prom program/verify controller
`default_nettype none
module ppv_prom_programmer_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE = 20;
    localparam int OW_PULSE = 60;
    localparam int RETRIES = 2;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_start = 1'b0;
    logic i_verify_only = 1'b0;
    logic [ppv_pkg::ADDR_W-1:0] i_addr = 17'h0;
    logic [ppv_pkg::DATA_W-1:0] i_data = 8'h00;
    logic o_busy, o_done, o_fail, o_range_err;
    logic [ppv_pkg::DATA_W-1:0] o_read_data, o_prom_data_bus, model_data, i_prom_data_bus;
    logic o_chip_sel_n, o_out_en_n, o_program_strobe_n, o_prom_data_oe, model_drive;
    logic [ppv_pkg::ADDR_W-1:0] o_prom_address_bus;
    int errors = 0;
    int total_checks = 0;
    int clash = 0;

    // clock and shared data wire
    always #2.5 i_clk_sys = ~i_clk_sys;
    assign i_prom_data_bus = o_prom_data_oe ? o_prom_data_bus : model_data;

    ppv_prom_programmer #(.PULSE_CYC(PULSE), .OW_PULSE_CYC(OW_PULSE), .RETRY_MAX(RETRIES)) dut (
        .i_clk_sys, .i_arst_n, .i_start, .i_verify_only, .i_addr, .i_data,
        .o_busy, .o_done, .o_fail, .o_range_err, .o_read_data,
        .o_chip_sel_n, .o_out_en_n, .o_program_strobe_n, .o_prom_address_bus,
        .o_prom_data_bus, .o_prom_data_oe, .i_prom_data_bus);

    ppv_prom_model #(.PW_NS(PULSE * 5), .OPW_NS(OW_PULSE * 5)) prom (
        .i_chip_sel_n(o_chip_sel_n), .i_out_en_n(o_out_en_n),
        .i_program_strobe_n(o_program_strobe_n), .i_prom_address_bus(o_prom_address_bus),
        .i_prom_data_bus(i_prom_data_bus), .o_prom_data_bus(model_data), .o_drive(model_drive));

    // both ends driving the data wire at once
    always @(posedge i_clk_sys) if (o_prom_data_oe === 1'b1 && model_drive === 1'b1) clash++;

    // compare a design value
    task automatic check_word(input logic [16:0] got, input logic [16:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // compare a count kept by the device model
    task automatic check_count(input int got, input int exp);
        total_checks++;
        if (got != exp) begin
            errors++;
            $display("Error at %0t: count %h expected %h", $time, got, exp);
        end
    endtask

    // one request, waits for its done pulse
    task automatic run_op(input logic vo, input logic [16:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge i_clk_sys);
        #1;
        i_start = 1'b1;
        i_verify_only = vo;
        i_addr = a;
        i_data = d;
        @(posedge i_clk_sys);
        #1;
        i_start = 1'b0;
        check_word(17'(o_busy), 17'h1);
        while (o_done !== 1'b1 && n < 8000) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        check_word(17'(o_done), 17'h1);
        check_word(17'(o_busy), 17'h0);
        check_word(17'(o_chip_sel_n), 17'h1);
    endtask

    // program one byte against a model needing need pulses
    task automatic write_case(input int need, input logic [16:0] a, input logic [7:0] d,
                              input int hits, input int ow, input logic fail, input logic rng);
        prom.clear(need);
        run_op(1'b0, a, d);
        check_word(17'(o_fail), 17'(fail));
        check_word(17'(o_range_err), 17'(rng));
        check_count(prom.hits, hits);
        check_count(prom.ow_hits, ow);
    endtask

    // pins idle while reset holds
    task automatic s_reset();
        check_word(17'({o_chip_sel_n, o_out_en_n, o_program_strobe_n, o_prom_data_oe}),
                   17'he);
        check_word(17'(o_busy), 17'h0);
    endtask

    // single pulse write then back to back verify reads
    task automatic s_write_verify();
        write_case(1, 17'h00010, 8'h5a, 1, 0, 1'b0, 1'b0);
        check_word(17'(prom.peek(16)), 17'h5a);
        run_op(1'b1, 17'h00010, 8'h5a);
        check_word(17'({o_fail, o_read_data}), 17'h05a);
        run_op(1'b1, 17'h00010, 8'h00);
        check_word(17'({o_fail, o_read_data}), 17'h15a);
    endtask

    // slow cells: retry, overwrite pass, overwrite fail
    task automatic s_retries();
        write_case(2, 17'h00020, 8'h3c, 2, 0, 1'b0, 1'b0);
        write_case(3, 17'h00030, 8'hc3, 3, 1, 1'b0, 1'b0);
        write_case(0, 17'h00040, 8'h00, 3, 1, 1'b1, 1'b0);
        check_word(17'(o_read_data), 17'hff);
    endtask

    // user area edges, an erased write accepted above it and a refused one
    task automatic s_range();
        write_case(1, 17'h0edff, 8'h00, 1, 0, 1'b0, 1'b0);
        write_case(1, 17'h0ee00, 8'hff, 0, 0, 1'b0, 1'b0);
        write_case(1, 17'h1ffff, 8'h12, 0, 0, 1'b1, 1'b1);
        check_count(prom.high_hits, 0);
        check_count(prom.bad, 0);
        check_count(clash, 0);
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // watchdog: run needs about 9200 cycles, allow 30000
    initial begin
        #(30000 * 5);
        errors++;
        finish_test();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge i_clk_sys);
        #1;
        s_reset();
        i_arst_n = 1'b1;
        s_write_verify();
        s_retries();
        s_range();
        finish_test();
    end
endmodule // ppv_prom_programmer_test
`default_nettype wire
